// [core/cfss_sync.sv]
`timescale 1ns/1ps
// Two-stage synchroniser for a group of pin levels
module cfss_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second stage
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// [core/cfss_top.sv]
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Summary of operation
// - Output multiplier set by two select bits
// - Byte 0 bit 0 picks pin or register
// - Hardware select bit resets to one
// - Register mode uses bits 1-4 and 6; pins ignored
// - Pin mode: spread on while pin low
// - Undriven spread pin reads as high
// - Bit 5: zero 1.0%, one 0.5%
// - Spread sweeps only below resting frequency
// - Bits 4,3 bank B; 2,1 bank A
// - Spread off, register mode: bit 5 picks synth2 or reference; pin mode: reference
module cfss_top (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic FREQ_SELECT_LOW_A,
  input wire logic BANK_A_SELECT_HIGH,
  input wire logic FREQ_SELECT_LOW_B,
  input wire logic BANK_B_SELECT_HIGH,
  input wire logic SPREAD_ENABLE_N_PIN,
  output logic [1:0] BANK_A_MULT_SEL,
  output logic [1:0] BANK_B_MULT_SEL,
  output logic SPREAD_MODULATOR_ON,
  output logic SPREAD_DOWN_ONLY,
  output logic [3:0] SPREAD_WIDTH_TENTHS,
  output logic [1:0] CLOCK_SOURCE,
  output logic TEST_MODE,
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [7:0] func_sel_r;
  logic [4:0] pins_s;
  logic aw_held_r, w_held_r;
  logic [3:0] awaddr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic hw_select_bit;
  logic [1:0] a_sel_nxt, b_sel_nxt;
  logic spread_nxt;
  logic write_go;
  cfss_pkg::cfss_src_t src_nxt;

  // Only the function byte offset is writable; shared by write enable and response
  function automatic logic is_func_addr(input logic [3:0] addr);
    return addr == cfss_pkg::CFSS_ADDR_FUNC_SEL;
  endfunction

  // Pin levels cross into the clock domain; spread pin idles high
  cfss_sync #(.WIDTH(5), .RST_VAL(5'h10)) u_pin_sync (
    .CLOCK(CLOCK),
    .RST(RST),
    .d({SPREAD_ENABLE_N_PIN, BANK_B_SELECT_HIGH, FREQ_SELECT_LOW_B, BANK_A_SELECT_HIGH, FREQ_SELECT_LOW_A}),
    .q(pins_s)
  );

  assign hw_select_bit = func_sel_r[cfss_pkg::CFSS_BIT_HW_SELECT];

  // Select source: pins in hardware mode, register bits otherwise
  always_comb begin
    if (hw_select_bit) begin
      a_sel_nxt = pins_s[1:0];
      b_sel_nxt = pins_s[3:2];
      spread_nxt = ~pins_s[4];
    end else begin
      a_sel_nxt = {func_sel_r[cfss_pkg::CFSS_BIT_A_HIGH], func_sel_r[cfss_pkg::CFSS_BIT_A_LOW]};
      b_sel_nxt = {func_sel_r[cfss_pkg::CFSS_BIT_B_HIGH], func_sel_r[cfss_pkg::CFSS_BIT_B_LOW]};
      spread_nxt = func_sel_r[cfss_pkg::CFSS_BIT_SPREAD_ON];
    end
    if (spread_nxt) begin
      src_nxt = cfss_pkg::CFSS_SRC_SPREAD;
    end else if (!hw_select_bit && !func_sel_r[cfss_pkg::CFSS_BIT_SPREAD_WIDTH]) begin
      src_nxt = cfss_pkg::CFSS_SRC_SYNTH2;
    end else begin
      src_nxt = cfss_pkg::CFSS_SRC_REF;
    end
  end

  // Bank multiplier selects
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      BANK_A_MULT_SEL <= 2'h0;
      BANK_B_MULT_SEL <= 2'h0;
    end else begin
      BANK_A_MULT_SEL <= a_sel_nxt;
      BANK_B_MULT_SEL <= b_sel_nxt;
    end
  end

  // Spread modulator enable and its downward-only sweep flag
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SPREAD_MODULATOR_ON <= 1'b0;
      SPREAD_DOWN_ONLY <= 1'b0;
    end else begin
      SPREAD_MODULATOR_ON <= spread_nxt;
      SPREAD_DOWN_ONLY <= spread_nxt;
    end
  end

  // Spread width follows the width bit in either control mode
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      SPREAD_WIDTH_TENTHS <= cfss_pkg::CFSS_SPREAD_NARROW;
    end else begin
      SPREAD_WIDTH_TENTHS <= func_sel_r[cfss_pkg::CFSS_BIT_SPREAD_WIDTH] ?
        cfss_pkg::CFSS_SPREAD_NARROW : cfss_pkg::CFSS_SPREAD_WIDE;
    end
  end

  // Frequency source for the output stages
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CLOCK_SOURCE <= cfss_pkg::CFSS_SRC_REF;
    end else begin
      CLOCK_SOURCE <= src_nxt;
    end
  end

  // Test mode is entered by clearing the top bit of the byte
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      TEST_MODE <= 1'b0;
    end else begin
      TEST_MODE <= ~func_sel_r[cfss_pkg::CFSS_BIT_TEST_N];
    end
  end

  // Write channel capture: address and data in either order, refused while a response waits
  assign S_AXI_AWREADY = ~aw_held_r & ~S_AXI_BVALID;
  assign S_AXI_WREADY = ~w_held_r & ~S_AXI_BVALID;
  assign write_go = aw_held_r & w_held_r;

  // Write address holding register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 4'h0;
    end else if (write_go) begin
      aw_held_r <= 1'b0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_r <= 1'b1;
      awaddr_r <= S_AXI_AWADDR;
    end
  end

  // Write data holding register: low byte and its strobe only
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (write_go) begin
      w_held_r <= 1'b0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_r <= 1'b1;
      wdata_r <= S_AXI_WDATA[7:0];
      wstrb0_r <= S_AXI_WSTRB[0];
    end
  end

  // Write response: read-only and unmapped offsets answer with an error
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= cfss_pkg::CFSS_RESP_OKAY;
    end else if (write_go) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= is_func_addr(awaddr_r) ? cfss_pkg::CFSS_RESP_OKAY : cfss_pkg::CFSS_RESP_SLVERR;
    end else if (S_AXI_BVALID && S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // Function select byte, hardware select set at reset
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      func_sel_r <= cfss_pkg::CFSS_FUNC_SEL_RST;
    end else if (write_go && wstrb0_r && is_func_addr(awaddr_r)) begin
      func_sel_r <= wdata_r;
    end
  end

  // Read channel: one read at a time
  assign S_AXI_ARREADY = ~S_AXI_RVALID;

  // Read valid: raised on acceptance, dropped once taken
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_RVALID <= 1'b0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  // Read data and response, loaded only on acceptance so they stand until taken
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= cfss_pkg::CFSS_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RRESP <= cfss_pkg::CFSS_RESP_OKAY;
      unique case (S_AXI_ARADDR)
        cfss_pkg::CFSS_ADDR_FUNC_SEL: S_AXI_RDATA <= {24'h0, func_sel_r};
        cfss_pkg::CFSS_ADDR_STATUS: S_AXI_RDATA <= {20'h0, SPREAD_WIDTH_TENTHS, CLOCK_SOURCE,
          SPREAD_MODULATOR_ON, TEST_MODE, BANK_B_MULT_SEL, BANK_A_MULT_SEL};
        cfss_pkg::CFSS_ADDR_PINS: S_AXI_RDATA <= {27'h0, pins_s};
        default: begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= cfss_pkg::CFSS_RESP_SLVERR;
        end
      endcase
    end
  end
endmodule

// [inc/cfss_pkg.sv]
package cfss_pkg;
  // AXI4-Lite register byte addresses
  localparam logic [3:0] CFSS_ADDR_FUNC_SEL = 4'h0;
  localparam logic [3:0] CFSS_ADDR_STATUS = 4'h4;
  localparam logic [3:0] CFSS_ADDR_PINS = 4'h8;

  // Function select byte field positions
  localparam int CFSS_BIT_HW_SELECT = 0;
  localparam int CFSS_BIT_A_LOW = 1;
  localparam int CFSS_BIT_A_HIGH = 2;
  localparam int CFSS_BIT_B_LOW = 3;
  localparam int CFSS_BIT_B_HIGH = 4;
  localparam int CFSS_BIT_SPREAD_WIDTH = 5;
  localparam int CFSS_BIT_SPREAD_ON = 6;
  localparam int CFSS_BIT_TEST_N = 7;

  // Function select byte reset value: normal, 0.5 % width, hardware select
  localparam logic [7:0] CFSS_FUNC_SEL_RST = 8'ha1;

  // Down-spread widths in tenths of a percent below nominal
  localparam logic [3:0] CFSS_SPREAD_WIDE = 4'ha;
  localparam logic [3:0] CFSS_SPREAD_NARROW = 4'h5;

  // Clock source codes: reference, synth2, or the spread modulator when spread is on
  typedef enum logic [1:0] {
    CFSS_SRC_REF = 2'b00,
    CFSS_SRC_SYNTH2 = 2'b01,
    CFSS_SRC_SPREAD = 2'b10
  } cfss_src_t;

  // AXI responses
  localparam logic [1:0] CFSS_RESP_OKAY = 2'b00;
  localparam logic [1:0] CFSS_RESP_SLVERR = 2'b10;
endpackage

// [tb/cfss_chk.sv]
`timescale 1ns/1ps
// Port checks for the selection block
module cfss_chk (
  input logic CLOCK,
  input logic RST,
  input logic SPREAD_MODULATOR_ON,
  input logic SPREAD_DOWN_ONLY,
  input logic [3:0] SPREAD_WIDTH_TENTHS,
  input logic [1:0] CLOCK_SOURCE,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Spread outputs agree, take legal codes and reset to known values
  a_down_only: assert property (SPREAD_DOWN_ONLY == SPREAD_MODULATOR_ON) else $error("sweep flag");
  a_spread_src: assert property (SPREAD_MODULATOR_ON |-> CLOCK_SOURCE == 2'h2) else $error("source on");
  a_plain_src: assert property (!SPREAD_MODULATOR_ON |-> CLOCK_SOURCE != 2'h2) else $error("source off");
  a_src_legal: assert property (CLOCK_SOURCE != 2'h3) else $error("source code");
  a_width_set: assert property (SPREAD_WIDTH_TENTHS inside {4'h5, 4'ha}) else $error("width");
  a_reset_state: assert property ($fell(RST) |-> !SPREAD_MODULATOR_ON && SPREAD_WIDTH_TENTHS == 4'h5)
    else $error("reset state");
  // Read handshake
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("no read data");
  a_read_once: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("read repeated");
endmodule
bind cfss_top cfss_chk i_cfss_chk (
  .CLOCK(CLOCK), .RST(RST), .SPREAD_MODULATOR_ON(SPREAD_MODULATOR_ON), .SPREAD_DOWN_ONLY(SPREAD_DOWN_ONLY),
  .SPREAD_WIDTH_TENTHS(SPREAD_WIDTH_TENTHS), .CLOCK_SOURCE(CLOCK_SOURCE), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
);

// [tb/cfss_strap.sv]
`timescale 1ns/1ps
// Board straps; spread pin pulled up when undriven
module cfss_strap (
  input logic [3:0] sel,
  input logic drv,
  input logic spr_n,
  output logic [4:0] pins
);
  // Pin levels set the frequency without any bus
  assign pins = {drv ? spr_n : 1'h1, sel};
endmodule

// [tb/cfss_top_tb.sv]
`timescale 1ns/1ps
// Table of settings, then a mid-run reset
module cfss_top_tb;
  logic CLOCK = 1'h0, RST = 1'h1, S_AXI_AWVALID = 1'h0, S_AXI_WVALID = 1'h0, S_AXI_BREADY = 1'h0;
  logic S_AXI_ARVALID = 1'h0, S_AXI_RREADY = 1'h0, drv = 1'h0, spn = 1'h1, ok;
  logic [3:0] S_AXI_AWADDR = 4'h0, S_AXI_ARADDR = 4'h0, S_AXI_WSTRB = 4'hf, sel = 4'h0, SPREAD_WIDTH_TENTHS;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rd;
  logic [1:0] BANK_A_MULT_SEL, BANK_B_MULT_SEL, CLOCK_SOURCE, S_AXI_BRESP, S_AXI_RRESP, rs, p, br, rr;
  logic SPREAD_MODULATOR_ON, SPREAD_DOWN_ONLY, TEST_MODE, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic S_AXI_RVALID, FREQ_SELECT_LOW_A, BANK_A_SELECT_HIGH, FREQ_SELECT_LOW_B, BANK_B_SELECT_HIGH, SPREAD_ENABLE_N_PIN;
  logic [4:0] pins;
  // Byte, pin settings, expected outputs; bit 0 is cleared before bit 6 is set
  logic [26:0] rows [6] = '{{8'ha1, 6'h1a, 13'h13ac}, {8'h21, 6'h3f, 13'h1e29}, {8'h81, 6'h25, 13'h0c50},
    {8'h9a, 6'h02, 13'h0e52}, {8'he6, 6'h3f, 13'h19ac}, {8'hac, 6'h28, 13'h1228}};
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  wire [12:0] outs = {BANK_A_MULT_SEL, BANK_B_MULT_SEL, SPREAD_MODULATOR_ON, SPREAD_DOWN_ONLY,
    SPREAD_WIDTH_TENTHS, CLOCK_SOURCE, TEST_MODE};
  assign {SPREAD_ENABLE_N_PIN, BANK_B_SELECT_HIGH, FREQ_SELECT_LOW_B, BANK_A_SELECT_HIGH, FREQ_SELECT_LOW_A} = pins;
  cfss_top i_cfss_top (
    .CLOCK(CLOCK), .RST(RST), .FREQ_SELECT_LOW_A(FREQ_SELECT_LOW_A), .BANK_A_SELECT_HIGH(BANK_A_SELECT_HIGH),
    .FREQ_SELECT_LOW_B(FREQ_SELECT_LOW_B), .BANK_B_SELECT_HIGH(BANK_B_SELECT_HIGH),
    .SPREAD_ENABLE_N_PIN(SPREAD_ENABLE_N_PIN), .BANK_A_MULT_SEL(BANK_A_MULT_SEL), .BANK_B_MULT_SEL(BANK_B_MULT_SEL),
    .SPREAD_MODULATOR_ON(SPREAD_MODULATOR_ON), .SPREAD_DOWN_ONLY(SPREAD_DOWN_ONLY),
    .SPREAD_WIDTH_TENTHS(SPREAD_WIDTH_TENTHS), .CLOCK_SOURCE(CLOCK_SOURCE), .TEST_MODE(TEST_MODE),
    .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
    .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY)
  );
  cfss_strap i_cfss_strap (.sel(sel), .drv(drv), .spr_n(spn), .pins(pins));
  // Clock
  initial forever #5 CLOCK = ~CLOCK;
  // Hang limit
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 2000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Bus write: each channel released when taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, d};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    p = 2'h3;
    while (p != 2'h0) begin
      @(negedge CLOCK);
      rs = p & {S_AXI_AWREADY, S_AXI_WREADY};
      @(posedge CLOCK);
      p = p & ~rs;
      {S_AXI_AWVALID, S_AXI_WVALID} <= p;
    end
    do begin
      @(negedge CLOCK);
      {ok, br} = {S_AXI_BVALID, S_AXI_BRESP};
      @(posedge CLOCK);
    end while (ok !== 1'h1);
    S_AXI_BREADY <= 1'h0;
  endtask
  // Bus read
  task automatic rdt(input logic [3:0] a);
    @(posedge CLOCK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(negedge CLOCK);
      ok = S_AXI_ARREADY;
      @(posedge CLOCK);
    end while (ok !== 1'h1);
    S_AXI_ARVALID <= 1'h0;
    do begin
      @(negedge CLOCK);
      {ok, rd, rr} = {S_AXI_RVALID, S_AXI_RDATA, S_AXI_RRESP};
      @(posedge CLOCK);
    end while (ok !== 1'h1);
    S_AXI_RREADY <= 1'h0;
  endtask
  task automatic stop_test();
    if (n_mismatch == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Row loop, then reset returns control to the pins
  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'h0;
    foreach (rows[i]) begin
      {sel, drv, spn} <= rows[i][18:13];
      wr(4'h0, rows[i][26:19]);
      chk("bresp", 32'(cfss_pkg::CFSS_RESP_OKAY), 32'(br));
      repeat (4) @(posedge CLOCK);
      chk("outs", 32'(rows[i][12:0]), 32'(outs));
    end
    // Mid-run reset: outputs take reset values, then pins regain control
    RST <= 1'h1;
    repeat (2) @(posedge CLOCK);
    @(negedge CLOCK);
    chk("rst_outs", 32'h28, 32'(outs));
    @(posedge CLOCK);
    RST <= 1'h0;
    rdt(4'h0);
    chk("func", 32'ha1, rd);
    repeat (4) @(posedge CLOCK);
    chk("outs", 32'h1428, 32'(outs));
    // Status and synchronised pins; undriven spread pin reads high
    rdt(4'h4);
    chk("status", 32'h50a, rd);
    rdt(4'h8);
    chk("pins", 32'h1a, rd);
    // Unmapped read, read-only write and masked write leave the byte alone
    rdt(4'hc);
    chk("rresp", 32'(cfss_pkg::CFSS_RESP_SLVERR), 32'(rr));
    chk("rdata", 32'h0, rd);
    wr(4'h4, 8'h00);
    chk("bresp", 32'(cfss_pkg::CFSS_RESP_SLVERR), 32'(br));
    S_AXI_WSTRB <= 4'he;
    wr(4'h0, 8'h00);
    S_AXI_WSTRB <= 4'hf;
    chk("bresp", 32'(cfss_pkg::CFSS_RESP_OKAY), 32'(br));
    rdt(4'h0);
    chk("func", 32'ha1, rd);
    chk("rresp", 32'(cfss_pkg::CFSS_RESP_OKAY), 32'(rr));
    stop_test();
  end
endmodule
